// ---- verification/nvh_dev_model.sv ----
// Behavioural model of the nonvolatile RAM device
`timescale 1ns/1ns
module nvh_dev_model #(parameter int SAVE_CLKS = 20) (
  input  wire logic        clk_i,
  input  wire logic [16:0] addr_i,
  input  wire logic        sel_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_o,
  input  wire logic        busy_n_i,
  output logic             busy_oe_o,
  input  wire logic        int_evt_i,
  input  wire logic        int_low_i,
  output logic             int_o
);
  logic [7:0] mem [0:131071];
  int saving = 0;
  int saves = 0;
  assign dq_oe_o = !sel_n_i && !oe_n_i && wr_n_i;
  assign dq_o = mem[addr_i];
  assign busy_oe_o = saving > 0;
  // Open drain low side drives the inverted event level, so the pin polarity flips
  assign int_o = int_low_i ? !int_evt_i : int_evt_i;
  always @(posedge clk_i) begin
    if (!sel_n_i && !wr_n_i) mem[addr_i] <= dq_i;
    if (saving > 0) saving <= saving - 1;
    else if (!busy_n_i) begin
      saving <= SAVE_CLKS;
      saves <= saves + 1;
    end
  end
endmodule : nvh_dev_model

// ---- verification/nvh_host_asserts.sv ----
// Checker on the host controller's device port
`timescale 1ns/1ns
module nvh_host_asserts (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [16:0] mem_addr_o,
  input wire logic        mem_sel_n_o,
  input wire logic        mem_wr_n_o,
  input wire logic        mem_oe_n_o,
  input wire logic        mem_dq_oe_o,
  input wire logic        hw_save_busy_n_i,
  input wire logic        hw_save_busy_n_o,
  input wire logic        hw_save_busy_n_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sel_len_a: assert property ($fell(mem_sel_n_o) |->
    (!mem_sel_n_o)[*5] ##1 mem_sel_n_o) else $error("select width wrong");
  go_delay_a: assert property ($fell(mem_sel_n_o) |-> $past(reg_wr_i, 2) &&
    $past(reg_addr_i, 2) == nvh_pkg::REG_CTRL) else $error("select without command");
  wr_in_sel_a: assert property (!mem_wr_n_o |-> !mem_sel_n_o && mem_oe_n_o)
    else $error("write strobe outside select");
  dq_drive_a: assert property (mem_dq_oe_o |-> !mem_wr_n_o && mem_oe_n_o)
    else $error("data driven outside write");
  oe_read_a: assert property (!mem_oe_n_o |-> !mem_sel_n_o && !mem_dq_oe_o)
    else $error("output enable clash");
  addr_hold_a: assert property (!mem_sel_n_o && !$past(mem_sel_n_o) |->
    $stable(mem_addr_o)) else $error("address moved in access");
  busy_wait_a: assert property ((!hw_save_busy_n_i)[*4] |-> !$fell(mem_sel_n_o))
    else $error("access while device busy");
  save_pulse_a: assert property ($rose(hw_save_busy_n_oe_o) |->
    (hw_save_busy_n_oe_o && !hw_save_busy_n_o)[*3] ##1 !hw_save_busy_n_oe_o)
    else $error("save pull width wrong");
  cover property ($fell(mem_wr_n_o));
  cover property ($fell(mem_oe_n_o));
  cover property ($rose(hw_save_busy_n_oe_o));
endmodule : nvh_host_asserts
bind nvh_host nvh_host_asserts nvh_host_asserts_inst (.clk_i, .rstn_i, .reg_addr_i,
  .reg_wr_i, .mem_addr_o, .mem_sel_n_o, .mem_wr_n_o, .mem_oe_n_o, .mem_dq_oe_o,
  .hw_save_busy_n_i, .hw_save_busy_n_o, .hw_save_busy_n_oe_o);

// ---- verification/nvh_host_tb.sv ----
// Self-checking bench for the host controller
`timescale 1ns/1ns
module nvh_host_tb;
  logic clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, int_evt = 0, int_low = 0;
  logic ext_pull = 0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, mem_dq_i, mem_dq_o, dev_dq, last_dq = 8'h00, d;
  logic [31:0] reg_rdata_o;
  logic [16:0] mem_addr_o, a;
  logic irq_o, mem_sel_n_o, mem_wr_n_o, mem_oe_n_o, mem_dq_oe_o, dev_oe, dev_bsy, dev_int_i;
  logic hw_save_busy_n_i, hw_save_busy_n_o, hw_save_busy_n_oe_o;
  int failures = 0, tests_run = 0, seed = 75, cyc = 0;
  // A released bus shows a changing pattern so a stale byte cannot pass
  assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : dev_oe ? dev_dq : ~last_dq;
  assign hw_save_busy_n_i = !((hw_save_busy_n_oe_o && !hw_save_busy_n_o) || dev_bsy ||
    ext_pull);
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    last_dq <= mem_dq_i;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  nvh_host nvh_host_inst (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .irq_o, .mem_addr_o, .mem_sel_n_o, .mem_wr_n_o, .mem_oe_n_o, .mem_dq_i,
    .mem_dq_o, .mem_dq_oe_o, .hw_save_busy_n_i, .hw_save_busy_n_o, .hw_save_busy_n_oe_o,
    .dev_int_i);
  nvh_dev_model nvh_dev_model_inst (.clk_i(clk_i), .addr_i(mem_addr_o), .sel_n_i(mem_sel_n_o),
    .wr_n_i(mem_wr_n_o), .oe_n_i(mem_oe_n_o), .dq_i(mem_dq_i), .dq_o(dev_dq), .dq_oe_o(dev_oe),
    .busy_n_i(hw_save_busy_n_i), .busy_oe_o(dev_bsy), .int_evt_i(int_evt),
    .int_low_i(int_low), .int_o(dev_int_i));
  task finish_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] exp_irq(input logic done, input logic saved, input logic dev);
    exp_irq = {29'h0, dev, saved, done};
  endfunction : exp_irq
  task wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= dt;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] ad, output logic [31:0] q);
    @(posedge clk_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask : rd
  task wait_idle;
    logic [31:0] q;
    for (int n = 0; n < 80; n++) begin
      rd(nvh_pkg::REG_STATUS, q);
      if (q[2:0] === 3'b010) return;
    end
    chk(q, 32'h2);
  endtask : wait_idle
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(nvh_pkg::REG_STATUS, q);
    chk(q, 32'h2);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : 17'($random(seed));
      d = 8'($random(seed));
      wr(nvh_pkg::REG_MASK, i[0] ? 8'h07 : 8'h00);
      wr(nvh_pkg::REG_ADDR, a[7:0]);
      wr(nvh_pkg::REG_ADDR_HI, a[15:8]);
      wr(nvh_pkg::REG_ADDR_TOP, {7'h00, a[16]});
      rd(nvh_pkg::REG_ADDR_HI, q);
      chk(q, {23'h0, a[16:8]});
      wr(nvh_pkg::REG_WDATA, d);
      wr(nvh_pkg::REG_CTRL, 8'h03);
      wait_idle();
      chk(nvh_dev_model_inst.mem[a], d);
      rd(nvh_pkg::REG_IRQ, q);
      chk(32'({q[0], irq_o}), {30'h0, 1'b1, i[0]});
      wr(nvh_pkg::REG_IRQ, 8'h07);
      nvh_dev_model_inst.mem[a] = ~d;
      wr(nvh_pkg::REG_CTRL, 8'h01);
      wait_idle();
      rd(nvh_pkg::REG_RDATA, q);
      chk(q, {24'h0, ~d});
      wr(nvh_pkg::REG_IRQ, 8'h07);
    end
    wr(nvh_pkg::REG_CTRL, 8'h04);
    repeat (8) @(posedge clk_i);
    chk(nvh_dev_model_inst.saves, 32'h1);
    rd(nvh_pkg::REG_STATUS, q);
    chk(q[2], 1'b1);
    wr(nvh_pkg::REG_CTRL, 8'h03);
    wait_idle();
    rd(nvh_pkg::REG_IRQ, q);
    chk(q, exp_irq(1'b0, 1'b1, 1'b0));
    wr(nvh_pkg::REG_IRQ, 8'h07);
    // An outside agent starts a save while the controller sits idle
    @(posedge clk_i);
    ext_pull <= 1'b1;
    repeat (3) @(posedge clk_i);
    ext_pull <= 1'b0;
    wr(nvh_pkg::REG_CTRL, 8'h03);
    chk(nvh_dev_model_inst.saves, 32'h2);
    wait_idle();
    rd(nvh_pkg::REG_IRQ, q);
    chk(q, exp_irq(1'b0, 1'b0, 1'b0));
    for (int p = 0; p < 2; p++) begin
      int_evt <= 1'b0;
      int_low <= p[0];
      wr(nvh_pkg::REG_CTRL, {4'h0, p[0], 3'h0});
      rd(nvh_pkg::REG_CTRL, q);
      chk(q, {28'h0, p[0], 3'h0});
      wr(nvh_pkg::REG_IRQ, 8'h07);
      rd(nvh_pkg::REG_IRQ, q);
      chk(q, exp_irq(1'b0, 1'b0, 1'b0));
      chk(irq_o, 1'b0);
      int_evt <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(nvh_pkg::REG_IRQ, q);
      chk(q, exp_irq(1'b0, 1'b0, 1'b1));
      chk(irq_o, 1'b1);
    end
    finish_test();
  end
endmodule : nvh_host_tb

// ---- verilog/nvh_host.sv ----
// Host controller driving the nonvolatile RAM parallel port
`timescale 1ns/1ns

//Function
// - Bytes move on one 8-bit two-way bus
// - Chip select driven low for every access
// - Write strobe low latches byte at select
// - Pulling busy pin low starts a save
module nvh_host (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic [3:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [31:0]                reg_rdata_o,
  output logic                            irq_o,
  output logic      [nvh_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                            mem_sel_n_o,
  output logic                            mem_wr_n_o,
  output logic                            mem_oe_n_o,
  input  wire logic [nvh_pkg::DATA_W-1:0] mem_dq_i,
  output logic      [nvh_pkg::DATA_W-1:0] mem_dq_o,
  output logic                            mem_dq_oe_o,
  input  wire logic                       hw_save_busy_n_i,
  output logic                            hw_save_busy_n_o,
  output logic                            hw_save_busy_n_oe_o,
  input  wire logic                       dev_int_i
);

  typedef enum logic [2:0] {S_IDLE, S_ACC, S_HOLD, S_SAVE, S_WAIT} nvh_state_t;

  nvh_state_t                 state, next_state;
  logic [3:0]                 cnt, next_cnt;
  nvh_pkg::nvh_bus_t          bus, next_bus;
  logic [7:0]                 dq_out, next_dq_out;
  logic                       dq_oe, next_dq_oe;
  logic                       save_oe, next_save_oe;
  logic [7:0]                 rdata, next_rdata;
  logic [nvh_pkg::ADDR_W-1:0] addr_r, next_addr_r;
  logic [7:0]                 wdata, next_wdata;
  logic                       is_write, next_is_write;
  logic                       ipol, next_ipol;
  logic [nvh_pkg::IRQ_W-1:0]  irq_st, next_irq_st;
  logic [nvh_pkg::IRQ_W-1:0]  mask, next_mask;
  logic [31:0]                rd_out, next_rd_out;
  logic                       irq, next_irq;
  logic [1:0]                 busy_sy, int_sy;
  logic [nvh_pkg::IRQ_W-1:0]  ev;

  // Pin inputs pass two flops; only the second stage is read
  logic [7:0] dq_s1, dq_s2;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_sy <= 2'h3;
      int_sy  <= 2'h0;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
    end else begin
      busy_sy <= {busy_sy[0], hw_save_busy_n_i};
      int_sy  <= {int_sy[0], dev_int_i};
      dq_s1   <= mem_dq_i;
      dq_s2   <= dq_s1;
    end
  end

  wire busy_low = !busy_sy[1];
  wire dev_int  = int_sy[1] ^ ipol;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_bus      = bus;
    next_dq_out   = dq_out;
    next_dq_oe    = dq_oe;
    next_save_oe  = save_oe;
    next_rdata    = rdata;
    next_addr_r   = addr_r;
    next_wdata    = wdata;
    next_is_write = is_write;
    next_ipol     = ipol;
    next_mask     = mask;
    ev            = '0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        nvh_pkg::REG_ADDR:  next_addr_r[7:0] = reg_wdata_i;
        nvh_pkg::REG_WDATA: next_wdata = reg_wdata_i;
        nvh_pkg::REG_MASK:  next_mask = reg_wdata_i[nvh_pkg::IRQ_W-1:0];
        nvh_pkg::REG_ADDR_HI:  next_addr_r[15:8] = reg_wdata_i;
        nvh_pkg::REG_ADDR_TOP: next_addr_r[nvh_pkg::ADDR_W-1] = reg_wdata_i[0];
        default: ;
      endcase
      if (reg_addr_i == nvh_pkg::REG_CTRL) begin
        next_ipol = reg_wdata_i[nvh_pkg::CTRL_IPOL];
      end
    end
    unique case (state)
      S_IDLE: begin
        // Commands are dropped while busy so no access overlaps a save
        if (reg_wr_i && reg_addr_i == nvh_pkg::REG_CTRL && !busy_low) begin
          if (reg_wdata_i[nvh_pkg::CTRL_SAVE]) begin
            next_save_oe = 1'b1;
            next_cnt     = 4'(nvh_pkg::SAVE_PULSE_CLKS);
            next_state   = S_SAVE;
          end else if (reg_wdata_i[nvh_pkg::CTRL_GO]) begin
            next_is_write  = reg_wdata_i[nvh_pkg::CTRL_WRITE];
            next_bus.addr  = next_addr_r;
            next_bus.sel_n = 1'b1;
            next_bus.wr_n  = 1'b1;
            next_bus.oe_n  = 1'b1;
            next_cnt       = 4'h1;
            next_state     = S_ACC;
          end
        end
      end
      S_ACC: begin
        // Address is set up a cycle before select falls
        next_bus.sel_n = 1'b0;
        if (is_write) begin
          next_bus.wr_n = 1'b0;
          next_dq_out   = wdata;
          next_dq_oe    = 1'b1;
        end else begin
          next_bus.oe_n = 1'b0;
        end
        next_cnt   = 4'(nvh_pkg::CYCLE_CLKS);
        next_state = S_HOLD;
      end
      S_HOLD: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          // No cycles are added for the two pin stages; dq_s2 holds the pins sampled two cycles before select rises
          if (!is_write) next_rdata = dq_s2;
          next_bus.sel_n = 1'b1;
          next_bus.wr_n  = 1'b1;
          next_bus.oe_n  = 1'b1;
          next_dq_oe     = 1'b0;
          ev[nvh_pkg::IRQ_DONE] = 1'b1;
          next_state     = S_IDLE;
        end
      end
      S_SAVE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_save_oe = 1'b0;
          next_state   = S_WAIT;
        end
      end
      S_WAIT: begin
        // Wait out the device store, which also covers its own stores
        if (!busy_low) begin
          ev[nvh_pkg::IRQ_SAVED] = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    ev[nvh_pkg::IRQ_DEV] = dev_int;

    next_irq_st = irq_st;
    if (reg_wr_i && reg_addr_i == nvh_pkg::REG_IRQ) begin
      next_irq_st = irq_st & ~reg_wdata_i[nvh_pkg::IRQ_W-1:0];
    end
    next_irq_st = next_irq_st | ev;
    next_irq    = |(next_irq_st & next_mask);

    next_rd_out = 32'h0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        nvh_pkg::REG_CTRL:   next_rd_out = {28'h0, ipol, 3'h0};
        nvh_pkg::REG_ADDR:   next_rd_out = {24'h0, addr_r[7:0]};
        nvh_pkg::REG_WDATA:  next_rd_out = {24'h0, wdata};
        nvh_pkg::REG_RDATA:  next_rd_out = {24'h0, rdata};
        nvh_pkg::REG_STATUS: next_rd_out = {29'h0, busy_low, state == S_IDLE, state != S_IDLE};
        nvh_pkg::REG_IRQ:    next_rd_out = {29'h0, irq_st};
        nvh_pkg::REG_MASK:   next_rd_out = {29'h0, mask};
        nvh_pkg::REG_ADDR_HI: next_rd_out = {23'h0, addr_r[nvh_pkg::ADDR_W-1:8]};
        default:             next_rd_out = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state    <= S_IDLE;
      cnt      <= 4'h0;
      bus      <= '{sel_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1, addr: '0};
      dq_out   <= 8'h00;
      dq_oe    <= 1'b0;
      save_oe  <= 1'b0;
      rdata    <= 8'h00;
      addr_r   <= '0;
      wdata    <= 8'h00;
      is_write <= 1'b0;
      ipol     <= 1'b0;
      irq_st   <= '0;
      mask     <= '0;
      rd_out   <= 32'h0;
      irq      <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      bus      <= next_bus;
      dq_out   <= next_dq_out;
      dq_oe    <= next_dq_oe;
      save_oe  <= next_save_oe;
      rdata    <= next_rdata;
      addr_r   <= next_addr_r;
      wdata    <= next_wdata;
      is_write <= next_is_write;
      ipol     <= next_ipol;
      irq_st   <= next_irq_st;
      mask     <= next_mask;
      rd_out   <= next_rd_out;
      irq      <= next_irq;
    end
  end

  assign reg_rdata_o         = rd_out;
  assign irq_o               = irq;
  assign mem_addr_o          = bus.addr;
  assign mem_sel_n_o         = bus.sel_n;
  assign mem_wr_n_o          = bus.wr_n;
  assign mem_oe_n_o          = bus.oe_n;
  assign mem_dq_o            = dq_out;
  assign mem_dq_oe_o         = dq_oe;
  assign hw_save_busy_n_o    = 1'b0;
  assign hw_save_busy_n_oe_o = save_oe;

endmodule : nvh_host

// ---- verilog/nvh_pkg.sv ----
// Package for the nonvolatile RAM host controller
package nvh_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // Register offsets of the controller's own register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ    = 4'h5;
  localparam logic [3:0] REG_MASK   = 4'h6;
  // The write port is eight bits wide, so the top address bit is written at an index of its own
  localparam logic [3:0] REG_ADDR_HI  = 4'h7;
  localparam logic [3:0] REG_ADDR_TOP = 4'h8;

  // Control bits
  localparam int CTRL_GO    = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_SAVE  = 2;
  localparam int CTRL_IPOL  = 3;

  // Interrupt bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_SAVED  = 1;
  localparam int IRQ_DEV    = 2;
  localparam int IRQ_W      = 3;

  // Bus timing, 45 ns cycle at 10 ns clock
  localparam int CLK_NS      = 10;
  localparam int CYCLE_NS    = 45;
  localparam int CYCLE_CLKS  = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_PULSE_NS   = 30;
  localparam int SAVE_PULSE_CLKS = (SAVE_PULSE_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic                  sel_n;
    logic                  wr_n;
    logic                  oe_n;
    logic [ADDR_W-1:0]     addr;
  } nvh_bus_t;

endpackage : nvh_pkg
